/* rtl/osem_top.sv */
// Summary of operation
// R1 - hold a 14-bit pump voltage monitor limit register
// R2 - limit counts 1024us units, resets to 0x3D0, about one second
// R3 - bit 7 sets when a manual request finishes; write one clears
// R4 - bit 6 latches macro status high; clearing while high sets again
// R5 - bit 5 flags pump voltage monitor high too long; clears only once condition gone
// R6 - bit 3 sets on program-assist failure; write one clears
// R7 - bit 2 sets when loader loads an empty configuration; write one clears
// R8 - bit 1 sets when the startup load fails; write one clears
// R9 - bit 0 sets on startup load CRC error; write one clears
// R10 - live bit 7 busy from manual request start until it ends
// R11 - live bit 6 shows present macro status level
// R12 - live bit 5 shows present pump voltage monitor level
// R13 - live bit 4 shows present macro power-up level
// R14 - live bits 2:0 report sequencer state with fixed codes
// R15 - 4-bit CRC error tally increments per loader CRC error, saturates 0xF
// R16 - writing zero clears the tally, other values preset it
// R17 - writing one to start runs a manual command when idle and not access protected
// R18 - busy drops and completion flag sets in the same cycle
// R19 - reserved bits read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none

`include "osem_map.svh"

module osem_top
    import osem_pkg::*;
#(
    parameter int TICK_CYCLES   = `OSEM_TICK_NS / `OSEM_CLK_NS,
    parameter int PWRUP_REC_CYC = `OSEM_PWRUP_REC_CYC,
    parameter int RESET_REC_CYC = `OSEM_RESET_REC_CYC,
    parameter int SETUP_CYC     = `OSEM_SETUP_CYC,
    parameter int PULSE_CYC     = `OSEM_PULSE_CYC,
    parameter int HOLD_CYC      = `OSEM_HOLD_CYC,
    parameter int RECOV_CYC     = `OSEM_RECOV_CYC
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic      [15:0] o_rdata,
    // macro pins, asynchronous
    input  wire logic        i_macro_status,
    input  wire logic        i_pump_voltage_monitor,
    input  wire logic        i_macro_pwr_up,
    // loader and program-assist events, same clock
    input  wire logic        i_access_protect,
    input  wire logic        i_assist_fail,
    input  wire logic        i_config_empty,
    input  wire logic        i_load_fail,
    input  wire logic        i_load_crc_error,
    input  wire logic        i_crc_detect,
    // macro strobes and interrupt
    output logic             o_macro_reset,
    output logic             o_macro_select,
    output logic             o_macro_pulse,
    output logic             o_irq
);

    // ****************************************
    // elaboration checks
    // ****************************************
    localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    if (TICK_CYCLES < 1 || PWRUP_REC_CYC < 1 || RESET_REC_CYC < 1) begin : g_bad_time
        $error("osem_top: timing counts must be at least one");
    end
    if (SETUP_CYC < 1 || PULSE_CYC < 1 || HOLD_CYC < 1 || RECOV_CYC < 1) begin : g_bad_seq
        $error("osem_top: sequence counts must be at least one");
    end
    if (PWRUP_REC_CYC > 256 || RESET_REC_CYC > 256 || PULSE_CYC > 256
            || RECOV_CYC > 256 || SETUP_CYC > 256 || HOLD_CYC > 256) begin : g_bad_len
        $error("osem_top: sequence counts must fit 8 bits");
    end

    localparam logic [7:0]       LD_PWRUP = 8'(PWRUP_REC_CYC - 1);
    localparam logic [7:0]       LD_RSTRC = 8'(RESET_REC_CYC - 1);
    localparam logic [7:0]       LD_SETUP = 8'(SETUP_CYC - 1);
    localparam logic [7:0]       LD_PULSE = 8'(PULSE_CYC - 1);
    localparam logic [7:0]       LD_HOLD  = 8'(HOLD_CYC - 1);
    localparam logic [7:0]       LD_RECOV = 8'(RECOV_CYC - 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pins_raw;
    logic [2:0] pins_sync;
    logic       status_s;
    logic       pump_mon_s;
    logic       pwr_up_s;

    assign pins_raw = {i_macro_pwr_up, i_pump_voltage_monitor, i_macro_status};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        osem_sync u_sync (
            .i_clock (i_clock),
            .i_reset (i_reset),
            .i_async (pins_raw[g]),
            .o_sync  (pins_sync[g])
        );
    end

    assign status_s   = pins_sync[0];
    assign pump_mon_s = pins_sync[1];
    assign pwr_up_s   = pins_sync[2];

    // ****************************************
    // bus strobes
    // ****************************************
    logic wr_limit;
    logic wr_events;
    logic wr_tally;
    logic wr_control;
    logic wr_mask;
    logic rd_irq;
    logic start_go;

    assign wr_limit   = i_write && hit(i_addr, `OSEM_ADDR_VPP_LIMIT);
    assign wr_events  = i_write && hit(i_addr, `OSEM_ADDR_EVENTS);
    assign wr_tally   = i_write && hit(i_addr, `OSEM_ADDR_CRC_TALLY);
    assign wr_control = i_write && hit(i_addr, `OSEM_ADDR_CONTROL);
    assign wr_mask    = i_write && hit(i_addr, `OSEM_ADDR_IRQ_MASK);
    assign rd_irq     = i_read && hit(i_addr, `OSEM_ADDR_IRQ_STATUS);
    // a protected start is dropped silently
    assign start_go   = wr_control && i_wdata[`OSEM_CTRL_START] && !i_access_protect; // see R17

    // ****************************************
    // control sequencer
    // ****************************************
    osem_state_t state;
    osem_state_t next_state;
    logic [7:0]  seq_cnt;
    logic [7:0]  next_seq_cnt;
    logic        busy;
    logic        done_pulse;

    always_comb begin
        next_state   = state;
        next_seq_cnt = seq_cnt;
        done_pulse   = 1'b0;
        if (seq_cnt != 8'h00) begin
            next_seq_cnt = seq_cnt - 8'h01;
        end
        case (state)
            ST_RESET: begin
                if (pwr_up_s) begin
                    next_state   = ST_PWR_UP_REC;
                    next_seq_cnt = LD_PWRUP;
                end
            end
            ST_PWR_UP_REC: begin
                if (seq_cnt == 8'h00) begin
                    next_state   = ST_RESET_REC;
                    next_seq_cnt = LD_RSTRC;
                end
            end
            ST_RESET_REC: begin
                if (seq_cnt == 8'h00) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // starts while busy are ignored: only idle accepts them
                if (start_go) begin // see R17
                    next_state   = ST_SETUP;
                    next_seq_cnt = LD_SETUP;
                end
            end
            ST_SETUP: begin
                if (seq_cnt == 8'h00) begin
                    next_state   = ST_PULSE;
                    next_seq_cnt = LD_PULSE;
                end
            end
            ST_PULSE: begin
                if (seq_cnt == 8'h00) begin
                    next_state   = ST_HOLD;
                    next_seq_cnt = LD_HOLD;
                end
            end
            ST_HOLD: begin
                if (seq_cnt == 8'h00) begin
                    next_state   = ST_RECOVERY;
                    next_seq_cnt = LD_RECOV;
                end
            end
            ST_RECOVERY: begin
                if (seq_cnt == 8'h00) begin
                    next_state = ST_IDLE;
                    done_pulse = 1'b1; // see R18
                end
            end
            default: begin
                next_state   = ST_RESET;
                next_seq_cnt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state   <= ST_RESET;
            seq_cnt <= 8'h00;
        end else begin
            state   <= next_state;
            seq_cnt <= next_seq_cnt;
        end
    end

    // busy and completion flag both follow the state register
    assign busy = (state == ST_SETUP) || (state == ST_PULSE)
                || (state == ST_HOLD) || (state == ST_RECOVERY); // see R10

    assign o_macro_reset  = (state == ST_RESET);
    assign o_macro_select = busy;
    assign o_macro_pulse  = (state == ST_PULSE);

    // ****************************************
    // pump voltage watchdog
    // ****************************************
    logic [`OSEM_LIMIT_W-1:0] vpp_limit;
    logic [`OSEM_LIMIT_W-1:0] next_vpp_limit;
    logic [`OSEM_LIMIT_W-1:0] vpp_ticks;
    logic [`OSEM_LIMIT_W-1:0] next_vpp_ticks;
    logic [PRE_W-1:0]         vpp_pre;
    logic [PRE_W-1:0]         next_vpp_pre;
    logic                     vpp_expired;

    // ticks only advance while the monitor is raised, and stop at the limit
    assign vpp_expired = pump_mon_s && (vpp_ticks >= vpp_limit); // see R5

    always_comb begin
        next_vpp_limit = vpp_limit;
        next_vpp_pre   = vpp_pre;
        next_vpp_ticks = vpp_ticks;
        if (wr_limit) begin
            next_vpp_limit = i_wdata[`OSEM_LIMIT_W-1:0]; // see R1
        end
        if (!pump_mon_s) begin
            next_vpp_pre   = '0;
            next_vpp_ticks = '0;
        end else if (!vpp_expired) begin
            if (vpp_pre == PRE_LAST) begin
                next_vpp_pre   = '0;
                next_vpp_ticks = vpp_ticks + 1'b1; // see R2
            end else begin
                next_vpp_pre = vpp_pre + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            vpp_limit <= `OSEM_LIMIT_RESET; // see R2
            vpp_pre   <= '0;
            vpp_ticks <= '0;
        end else begin
            vpp_limit <= next_vpp_limit;
            vpp_pre   <= next_vpp_pre;
            vpp_ticks <= next_vpp_ticks;
        end
    end

    // ****************************************
    // event flags, tally, interrupt
    // ****************************************
    logic [7:0] events;
    logic [7:0] next_events;
    logic [7:0] evt_set;
    logic [7:0] evt_clr;
    logic [7:0] irq_status;
    logic [7:0] next_irq_status;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_mask;
    logic [3:0] tally;
    logic [3:0] next_tally;

    always_comb begin
        evt_set = 8'h00;
        evt_set[`OSEM_EVT_MANUAL_DONE] = done_pulse;       // see R3
        evt_set[`OSEM_EVT_STATUS_HELD] = status_s;         // see R4
        evt_set[`OSEM_EVT_VPP_ERROR]   = vpp_expired;      // see R5
        evt_set[`OSEM_EVT_ASSIST_FAIL] = i_assist_fail;    // see R6
        evt_set[`OSEM_EVT_CFG_EMPTY]   = i_config_empty;   // see R7
        evt_set[`OSEM_EVT_LOAD_FAIL]   = i_load_fail;      // see R8
        evt_set[`OSEM_EVT_CRC_ERROR]   = i_load_crc_error; // see R9
        evt_clr = wr_events ? (i_wdata[7:0] & `OSEM_EVT_USED) : 8'h00; // see R19
        // set beats clear, so a live cause re-arms the flag at once
        next_events = evt_set | (events & ~evt_clr);
        next_irq_status = evt_set | (rd_irq ? 8'h00 : irq_status);
        next_irq_mask   = wr_mask ? (i_wdata[7:0] & `OSEM_EVT_USED) : irq_mask;
        next_tally = tally;
        if (wr_tally) begin
            // software preset wins over a same-cycle detection
            next_tally = i_wdata[3:0]; // see R16
        end else if (i_crc_detect && tally != `OSEM_TALLY_MAX) begin
            next_tally = tally + 4'h1; // see R15
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            events     <= 8'h00;
            irq_status <= 8'h00;
            irq_mask   <= 8'h00;
            tally      <= `OSEM_TALLY_ZERO;
        end else begin
            events     <= next_events;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            tally      <= next_tally;
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // ****************************************
    // read data
    // ****************************************
    logic [15:0] next_rdata;
    logic [7:0]  live;

    always_comb begin
        live = 8'h00;
        live[`OSEM_LIVE_BUSY]     = busy;       // see R10
        live[`OSEM_LIVE_STATUS]   = status_s;   // see R11
        live[`OSEM_LIVE_PUMP_MON] = pump_mon_s; // see R12
        live[`OSEM_LIVE_PWR_UP]   = pwr_up_s;   // see R13
        live[2:0]                 = state;      // see R14
        next_rdata = 16'h0000;
        if (i_read) begin
            case (i_addr)
                `OSEM_ADDR_VPP_LIMIT:  next_rdata = {2'b00, vpp_limit}; // see R19
                `OSEM_ADDR_EVENTS:     next_rdata = {8'h00, events};
                `OSEM_ADDR_LIVE:       next_rdata = {8'h00, live};
                `OSEM_ADDR_CRC_TALLY:  next_rdata = {12'h000, tally};
                `OSEM_ADDR_IRQ_STATUS: next_rdata = {8'h00, irq_status};
                `OSEM_ADDR_IRQ_MASK:   next_rdata = {8'h00, irq_mask};
                default:               next_rdata = 16'h0000;
            endcase
        end
    end

    // data stands one cycle only, zero otherwise
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule : osem_top

`default_nettype wire

/* rtl/osem_map.svh */
`ifndef OSEM_MAP_SVH
`define OSEM_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define OSEM_ADDR_VPP_LIMIT  8'h00
`define OSEM_ADDR_EVENTS     8'h04
`define OSEM_ADDR_LIVE       8'h08
`define OSEM_ADDR_CRC_TALLY  8'h0C
`define OSEM_ADDR_CONTROL    8'h10
`define OSEM_ADDR_IRQ_STATUS 8'h14
`define OSEM_ADDR_IRQ_MASK   8'h18

// ****************************************
// field positions
// ****************************************
`define OSEM_EVT_MANUAL_DONE 7
`define OSEM_EVT_STATUS_HELD 6
`define OSEM_EVT_VPP_ERROR   5
`define OSEM_EVT_ASSIST_FAIL 3
`define OSEM_EVT_CFG_EMPTY   2
`define OSEM_EVT_LOAD_FAIL   1
`define OSEM_EVT_CRC_ERROR   0
`define OSEM_LIVE_BUSY       7
`define OSEM_LIVE_STATUS     6
`define OSEM_LIVE_PUMP_MON   5
`define OSEM_LIVE_PWR_UP     4
`define OSEM_CTRL_START      0
`define OSEM_EVT_USED        8'hEF

// ****************************************
// reset values and limits
// ****************************************
`define OSEM_LIMIT_W         14
`define OSEM_LIMIT_RESET     14'h03D0
`define OSEM_TALLY_MAX       4'hF
`define OSEM_TALLY_ZERO      4'h0

// ****************************************
// timing
// ****************************************
`define OSEM_TICK_NS         1024000
`define OSEM_CLK_NS          4
`define OSEM_PWRUP_REC_CYC   16
`define OSEM_RESET_REC_CYC   16
`define OSEM_SETUP_CYC       1
`define OSEM_PULSE_CYC       12
`define OSEM_HOLD_CYC        1
`define OSEM_RECOV_CYC       11

`endif

/* rtl/osem_pkg.sv */
`default_nettype none

package osem_pkg;

    // control sequencer, codes as reported to software
    typedef enum logic [2:0] {
        ST_RESET       = 3'h0,
        ST_PWR_UP_REC  = 3'h1,
        ST_RESET_REC   = 3'h2,
        ST_HOLD        = 3'h3,
        ST_IDLE        = 3'h4,
        ST_SETUP       = 3'h5,
        ST_RECOVERY    = 3'h6,
        ST_PULSE       = 3'h7
    } osem_state_t;

endpackage : osem_pkg

`default_nettype wire

/* rtl/osem_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module osem_sync (
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_async,
    output logic      o_sync
);

    logic stage_a;
    logic stage_b;

    // first stage feeds only the second
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
        end else begin
            stage_a <= i_async;
            stage_b <= stage_a;
        end
    end

    assign o_sync = stage_b;

endmodule : osem_sync

`default_nettype wire

/* testbench/osem_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osem_map.svh"

// ****************************************
// port checker
// ****************************************
module osem_chk #(
    parameter int SETUP_CYC = 1,
    parameter int PULSE_CYC = 12,
    parameter int HOLD_CYC  = 1,
    parameter int RECOV_CYC = 11
) (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_write,
    input wire logic        i_read,
    input wire logic [15:0] o_rdata,
    input wire logic        i_access_protect,
    input wire logic        o_macro_reset,
    input wire logic        o_macro_select,
    input wire logic        o_macro_pulse,
    input wire logic        o_irq
);
    logic [10:0] sel_cnt;
    logic [10:0] next_sel_cnt;
    logic [10:0] pls_cnt;
    logic [10:0] next_pls_cnt;

    // run lengths, cleared when low so a reset mid-run cannot leak
    always_comb begin
        next_sel_cnt = o_macro_select ? sel_cnt + 11'h001 : 11'h000;
        next_pls_cnt = o_macro_pulse ? pls_cnt + 11'h001 : 11'h000;
    end
    always_ff @(posedge i_clock) begin
        sel_cnt <= i_reset ? 11'h000 : next_sel_cnt;
        pls_cnt <= i_reset ? 11'h000 : next_pls_cnt;
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);

    property p_rdata_rest;
        !$past(i_read) |-> o_rdata == 16'h0000;
    endproperty
    a_rdata_rest: assert property (p_rdata_rest) else $error("read data not zero");
    property p_unmapped;
        i_read && (i_addr >= 8'h1C) |=> o_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_read;
        i_read && i_addr == `OSEM_ADDR_CONTROL |=> o_rdata == 16'h0000;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("start bit reads back");
    property p_limit_width;
        i_read && i_addr == `OSEM_ADDR_VPP_LIMIT |=> o_rdata[15:14] == 2'b00;
    endproperty
    a_limit_width: assert property (p_limit_width) else $error("limit upper bits set");
    property p_evt_rsvd;
        i_read && i_addr == `OSEM_ADDR_EVENTS |=> o_rdata[15:8] == 8'h00 && !o_rdata[4];
    endproperty
    a_evt_rsvd: assert property (p_evt_rsvd) else $error("event reserved bit set");
    property p_live_busy;
        i_read && i_addr == `OSEM_ADDR_LIVE |=> o_rdata[7] == $past(o_macro_select);
    endproperty
    a_live_busy: assert property (p_live_busy) else $error("busy bit wrong");
    property p_live_state;
        i_read && i_addr == `OSEM_ADDR_LIVE && (o_macro_reset || o_macro_pulse)
            |=> o_rdata[2:0] == ($past(o_macro_pulse) ? 3'h7 : 3'h0);
    endproperty
    a_live_state: assert property (p_live_state) else $error("state code wrong");
    property p_protect;
        i_write && i_addr == `OSEM_ADDR_CONTROL && i_access_protect && !o_macro_select
            |=> !o_macro_select;
    endproperty
    a_protect: assert property (p_protect) else $error("protected start ran");
    property p_sel_len;
        $fell(o_macro_select) |-> sel_cnt == 11'(SETUP_CYC + PULSE_CYC + HOLD_CYC + RECOV_CYC);
    endproperty
    a_sel_len: assert property (p_sel_len) else $error("busy length wrong");
    property p_pls_len;
        $fell(o_macro_pulse) |-> pls_cnt == 11'(PULSE_CYC) && o_macro_select;
    endproperty
    a_pls_len: assert property (p_pls_len) else $error("pulse length wrong");
    property p_mask_off;
        i_write && i_addr == `OSEM_ADDR_IRQ_MASK && i_wdata[7:0] == 8'h00 |=> !o_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq high");
    property p_pulse_sel;
        o_macro_pulse |-> o_macro_select && !o_macro_reset;
    endproperty
    a_pulse_sel: assert property (p_pulse_sel) else $error("pulse outside busy");

    c_done: cover property ($fell(o_macro_select));
    c_irq: cover property ($rose(o_irq));
    c_protect: cover property (i_write && i_addr == `OSEM_ADDR_CONTROL && i_access_protect);
endmodule : osem_chk

bind osem_top osem_chk #(
    .SETUP_CYC(SETUP_CYC), .PULSE_CYC(PULSE_CYC), .HOLD_CYC(HOLD_CYC), .RECOV_CYC(RECOV_CYC)
) chk_u (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_access_protect(i_access_protect),
    .o_macro_reset(o_macro_reset), .o_macro_select(o_macro_select),
    .o_macro_pulse(o_macro_pulse), .o_irq(o_irq)
);
`default_nettype wire

/* testbench/osem_macro_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// memory macro and charge pump
// ****************************************
module osem_macro_model #(
    parameter int RAMP_CYC = 4
) (
    input  wire logic i_clock,
    input  wire logic i_power_on,
    input  wire logic i_status_req,
    input  wire logic i_pump_req,
    output logic      o_pwr_up,
    output logic      o_status,
    output logic      o_pump_mon
);
    int ramp = 0;

    // slow supply ramp; pins change off edge like a real async source
    always @(posedge i_clock) begin
        ramp <= i_power_on ? ((ramp < RAMP_CYC) ? ramp + 1 : ramp) : 0;
        o_pwr_up <= #1 i_power_on && (ramp >= RAMP_CYC);
        o_status <= #1 i_status_req;
        o_pump_mon <= #1 i_pump_req;
    end
endmodule : osem_macro_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osem_map.svh"

// ****************************************
// testbench
// ****************************************
module tb_top;
    logic        i_clock = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [15:0] wdata   = 16'h0000;
    logic        write   = 1'b0;
    logic        read    = 1'b0;
    logic [3:0]  ev_in   = 4'h0;
    logic        crc_det = 1'b0;
    logic        protect = 1'b0;
    logic        pwr_on  = 1'b1;
    logic        sts_req = 1'b0;
    logic        pmp_req = 1'b0;
    logic [15:0] rdata;
    logic        pwr_up;
    logic        status;
    logic        pump;
    logic        irq;
    logic        sel;
    logic        pulse;
    logic        mreset;
    int          mismatches = 0;
    int          tests_run = 0;
    int          n;

    always #2 i_clock = ~i_clock;

    // watchdog shortened: four clocks per monitor tick
    osem_top #(.TICK_CYCLES(4)) dut_u (
        .i_clock(i_clock), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
        .i_write(write), .i_read(read), .o_rdata(rdata), .i_macro_status(status),
        .i_pump_voltage_monitor(pump), .i_macro_pwr_up(pwr_up),
        .i_access_protect(protect), .i_assist_fail(ev_in[3]), .i_config_empty(ev_in[2]),
        .i_load_fail(ev_in[1]), .i_load_crc_error(ev_in[0]), .i_crc_detect(crc_det),
        .o_macro_reset(mreset), .o_macro_select(sel), .o_macro_pulse(pulse), .o_irq(irq)
    );
    osem_macro_model macro_u (
        .i_clock(i_clock), .i_power_on(pwr_on), .i_status_req(sts_req),
        .i_pump_req(pmp_req), .o_pwr_up(pwr_up), .o_status(status), .o_pump_mon(pump)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge i_clock);
        write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_clock);
        addr <= a;
        read <= 1'b1;
        @(posedge i_clock);
        read <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (11) @(posedge i_clock);
        #1 chk({15'h0000, mreset}, 16'h0001);
        @(posedge i_clock) i_reset <= 1'b0;
        // power-up plus both recovery spans before idle
        repeat (45) @(posedge i_clock);
        rd(`OSEM_ADDR_VPP_LIMIT, 16'h03D0);
        rd(`OSEM_ADDR_EVENTS, 16'h0000);
        rd(`OSEM_ADDR_CRC_TALLY, 16'h0000);
        rd(`OSEM_ADDR_LIVE, 16'h0014);
        chk({15'h0000, mreset}, 16'h0000);
        rd(`OSEM_ADDR_CONTROL, 16'h0000);
        rd(8'h1C, 16'h0000);
        wr(`OSEM_ADDR_VPP_LIMIT, 16'hFFFF);
        rd(`OSEM_ADDR_VPP_LIMIT, 16'h3FFF);
        @(posedge i_clock) pmp_req <= 1'b1;
        repeat (20) @(posedge i_clock);
        rd(`OSEM_ADDR_EVENTS, 16'h0000);
        rd(`OSEM_ADDR_LIVE, 16'h0034);
        wr(`OSEM_ADDR_VPP_LIMIT, 16'h0000);
        repeat (5) @(posedge i_clock);
        rd(`OSEM_ADDR_EVENTS, 16'h0020);
        wr(`OSEM_ADDR_EVENTS, 16'h0020);
        rd(`OSEM_ADDR_EVENTS, 16'h0020);
        @(posedge i_clock) pmp_req <= 1'b0;
        repeat (5) @(posedge i_clock);
        wr(`OSEM_ADDR_EVENTS, 16'h0020);
        rd(`OSEM_ADDR_EVENTS, 16'h0000);
        @(posedge i_clock) sts_req <= 1'b1;
        repeat (5) @(posedge i_clock);
        rd(`OSEM_ADDR_LIVE, 16'h0054);
        wr(`OSEM_ADDR_EVENTS, 16'h0040);
        rd(`OSEM_ADDR_EVENTS, 16'h0040);
        @(posedge i_clock) sts_req <= 1'b0;
        repeat (5) @(posedge i_clock);
        rd(`OSEM_ADDR_EVENTS, 16'h0040);
        wr(`OSEM_ADDR_EVENTS, 16'h0040);
        rd(`OSEM_ADDR_EVENTS, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clock) ev_in <= 4'(1 << i);
            @(posedge i_clock) ev_in <= 4'h0;
            rd(`OSEM_ADDR_EVENTS, 16'(1 << i));
            wr(`OSEM_ADDR_EVENTS, 16'hFF00 | 16'(1 << i));
            rd(`OSEM_ADDR_EVENTS, 16'h0000);
        end
        // one past the ceiling proves it holds rather than wraps
        @(posedge i_clock) crc_det <= 1'b1;
        repeat (16) @(posedge i_clock);
        crc_det <= 1'b0;
        rd(`OSEM_ADDR_CRC_TALLY, 16'h000F);
        wr(`OSEM_ADDR_CRC_TALLY, 16'hFFF5);
        rd(`OSEM_ADDR_CRC_TALLY, 16'h0005);
        wr(`OSEM_ADDR_CRC_TALLY, 16'h0000);
        rd(`OSEM_ADDR_CRC_TALLY, 16'h0000);
        @(posedge i_clock) protect <= 1'b1;
        wr(`OSEM_ADDR_CONTROL, 16'h0001);
        rd(`OSEM_ADDR_LIVE, 16'h0014);
        @(posedge i_clock) protect <= 1'b0;
        wr(`OSEM_ADDR_CONTROL, 16'h0001);
        rd(`OSEM_ADDR_LIVE, 16'h0097);
        chk({14'h0000, sel, pulse}, 16'h0003);
        for (n = 0; n < 40 && sel !== 1'b0; n++) @(posedge i_clock);
        chk({15'h0000, sel}, 16'h0000);
        rd(`OSEM_ADDR_EVENTS, 16'h0080);
        rd(`OSEM_ADDR_LIVE, 16'h0014);
        wr(`OSEM_ADDR_EVENTS, 16'h0080);
        rd(`OSEM_ADDR_EVENTS, 16'h0000);
        rd(`OSEM_ADDR_IRQ_STATUS, 16'h00EF);
        chk({15'h0000, irq}, 16'h0000);
        wr(`OSEM_ADDR_IRQ_MASK, 16'h00FF);
        @(posedge i_clock) ev_in <= 4'h2;
        @(posedge i_clock) ev_in <= 4'h0;
        repeat (2) @(posedge i_clock);
        #1 chk({15'h0000, irq}, 16'h0001);
        rd(`OSEM_ADDR_IRQ_STATUS, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        wr(`OSEM_ADDR_IRQ_MASK, 16'h0000);
        stop_test();
    end

    // whole sequence is well under a thousand clocks
    initial begin
        repeat (5000) @(posedge i_clock);
        mismatches++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
